// ===== dv/tb.sv
/* Self-checking bench of the watchdog control block.
 * Assumes shortened counts: tick every 2 cycles, base period 4 ticks. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import wtc_pkg::*;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic        rsr = 1, vack = 0, gie = 0, mon = 0, fuse = 0, cause = 0;
	wire logic [31:0] rdat;
	wire logic        ack, irq, srst;
	int          error_cnt = 0, check_count = 0, rst_seen = 0, cyc_cnt = 0;
	int          n;
	logic [3:0]  s, p;
	wtc_core #(.OSC_DIV(2), .BASE_OSC(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(4'h1), .wb_dat_o(rdat), .wb_ack_o(ack),
		.restart_i(rsr), .vector_ack_i(vack), .glob_irq_en_i(gie),
		.clk_monitor_i(mon), .always_on_fuse_i(fuse),
		.reset_cause_flag_i(cause), .irq_o(irq), .sys_reset_o(srst));
	always #10 clk_i = ~clk_i;
	// Count reset requests, cut a hang short
	always @(posedge clk_i) begin
		if (srst === 1'b1) rst_seen <= rst_seen + 1;
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("Errors %0d, checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		check_count++;
		if (v !== e) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, v, e);
		end
	endtask : chk
	// One classic Wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h00_0000, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask : wb
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask : rc
	// Wait for an irq or a reset request, counting cycles
	task automatic wev(input logic r, input int lim, output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (((r ? srst : irq) !== 1'b1) && k < lim);
	endtask : wev
	task automatic pulse_vack();
		@(posedge clk_i) vack <= 1;
		@(posedge clk_i) vack <= 0;
	endtask : pulse_vack
	task automatic t_irq();
		rc(WTC_CTRL_ADDR, 32'h0000_0000);
		rc(WTC_STAT_ADDR, 32'h0000_0001);
		wr(WTC_STAT_ADDR, 8'hff);
		rc(4'h8, 32'h0000_0000);
		gie <= 1;
		wr(WTC_CTRL_ADDR, 8'h40);
		rc(WTC_STAT_ADDR, 32'h0000_0002);
		rsr <= 0;
		wev(1'b0, 64, n);
		rsr <= 1;
		chk(irq, 1'b1);
		rc(WTC_CTRL_ADDR, 32'h0000_00c0);
		gie <= 0;
		repeat (3) @(posedge clk_i);
		chk(irq, 1'b0);
		wr(WTC_CTRL_ADDR, 8'hc0);
		rc(WTC_CTRL_ADDR, 32'h0000_0040);
		{gie, rsr} <= 2'b10;
		wev(1'b0, 64, n);
		rsr <= 1;
		pulse_vack();
		rc(WTC_CTRL_ADDR, 32'h0000_0040);
		chk(rst_seen, 0);
	endtask : t_irq
	task automatic t_both();
		wr(WTC_CTRL_ADDR, 8'h48);
		rc(WTC_STAT_ADDR, 32'h0000_0008);
		rsr <= 0;
		wev(1'b0, 64, n);
		rsr <= 1;
		pulse_vack();
		rc(WTC_CTRL_ADDR, 32'h0000_0008);
		rc(WTC_STAT_ADDR, 32'h0000_0004);
		wr(WTC_CTRL_ADDR, 8'h48);
		rsr <= 0;
		wev(1'b1, 64, n);
		rsr <= 1;
		chk(n >= 12 && n <= 24, 1'b1);
		gie <= 0;
	endtask : t_both
	task automatic t_unlock();
		wr(WTC_CTRL_ADDR, 8'h81);
		rc(WTC_CTRL_ADDR, 32'h0000_0008);
		wr(WTC_CTRL_ADDR, 8'h18);
		wr(WTC_CTRL_ADDR, 8'h01);
		rc(WTC_CTRL_ADDR, 32'h0000_0001);
		wr(WTC_CTRL_ADDR, 8'h19);
		rc(WTC_STAT_ADDR, 32'h0000_0014);
		repeat (6) @(posedge clk_i);
		rc(WTC_STAT_ADDR, 32'h0000_0004);
		wr(WTC_CTRL_ADDR, 8'h00);
		rc(WTC_CTRL_ADDR, 32'h0000_0009);
	endtask : t_unlock
	// Period codes, the longest and one reserved
	task automatic t_period();
		logic [3:0] e;
		p = 4'h1;
		for (int i = 0; i < 4; i++) begin
			s = (i == 0) ? 4'h0 : (i == 1) ? 4'h2 : (i == 2) ? 4'h9 : 4'hf;
			e = (s > WTC_SEL_MAX) ? WTC_SEL_MAX : s;
			wr(WTC_CTRL_ADDR, {2'b00, p[3], 2'b11, p[2:0]});
			wr(WTC_CTRL_ADDR, {2'b00, s[3], 2'b01, s[2:0]});
			rc(WTC_CTRL_ADDR, {26'h0, s[3], 2'b01, s[2:0]});
			rsr <= 0;
			wev(1'b1, 5000, n);
			rsr <= 1;
			chk(n + 2 >= (8 << e) && n <= (8 << e) + 4, 1'b1);
			p = s;
		end
	endtask : t_period
	task automatic t_forced();
		{cause, rst_i} <= 2'b11;
		@(posedge clk_i) rst_i <= 0;
		rc(WTC_STAT_ADDR, 32'h0000_0004);
		wr(WTC_CTRL_ADDR, 8'h18);
		wr(WTC_CTRL_ADDR, 8'h00);
		rc(WTC_CTRL_ADDR, 32'h0000_0008);
		cause <= 0;
		wr(WTC_CTRL_ADDR, 8'h18);
		wr(WTC_CTRL_ADDR, 8'h00);
		rc(WTC_STAT_ADDR, 32'h0000_0001);
		fuse <= 1;
		wr(WTC_CTRL_ADDR, 8'h40);
		rc(WTC_CTRL_ADDR, 32'h0000_0008);
		fuse <= 0;
		wr(WTC_CTRL_ADDR, 8'h40);
		mon <= 1;
		rc(WTC_STAT_ADDR, 32'h0000_0004);
		mon <= 0;
	endtask : t_forced
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		t_irq();
		t_both();
		t_unlock();
		t_period();
		t_forced();
		give_verdict();
	end
endmodule : tb
`default_nettype wire

// ===== dv/wtc_core_properties.sv
/* Checker of the watchdog control block's port behaviour.
 * Assumes one clock clk_i and the synchronous reset rst_i. */
`timescale 1ns/1ps
`default_nettype none
module wtc_core_properties
	import wtc_pkg::*;
(
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Sideband and events
	input wire logic        restart_i,
	input wire logic        glob_irq_en_i,
	input wire logic        clk_monitor_i,
	input wire logic        always_on_fuse_i,
	input wire logic        irq_o,
	input wire logic        sys_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request and its one-cycle answer
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack; s_req |=> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("Bus answer late or long");
	property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	a_idle: assert property (p_idle) else $error("Ack without request");
	property p_upper; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000;
	endproperty
	a_upper: assert property (p_upper) else $error("Upper read bits set");
	property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i != WTC_CTRL_ADDR &&
		wb_adr_i != WTC_STAT_ADDR |-> wb_dat_o == 32'h0000_0000; endproperty
	a_unmap: assert property (p_unmap) else $error("Unmapped read not zero");
	// Interrupt gating and forced modes
	property p_gie; !glob_irq_en_i |=> !irq_o; endproperty
	a_gie: assert property (p_gie) else $error("Irq without global enable");
	property p_mon; clk_monitor_i [*2] |=> !irq_o; endproperty
	a_mon: assert property (p_mon) else $error("Irq under clock monitor");
	property p_fuse; always_on_fuse_i [*3] |=> !irq_o; endproperty
	a_fuse: assert property (p_fuse) else $error("Irq with fuse set");
	// Reset request pulse and restart
	property p_pulse; sys_reset_o |=> !sys_reset_o; endproperty
	a_pulse: assert property (p_pulse) else $error("Reset pulse too long");
	property p_restart; restart_i [*3] |=> !sys_reset_o; endproperty
	a_restart: assert property (p_restart) else $error("Reset despite restart");
endmodule : wtc_core_properties
bind wtc_core wtc_core_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.restart_i(restart_i), .glob_irq_en_i(glob_irq_en_i),
	.clk_monitor_i(clk_monitor_i), .always_on_fuse_i(always_on_fuse_i),
	.irq_o(irq_o), .sys_reset_o(sys_reset_o));
`default_nettype wire

// ===== include/wtc_pkg.sv
/*
 * Package for the watchdog timer control block: register map, field
 * positions, reset values, timing counts, mode codes and the layout of
 * the control register.
 * Assumes a 50 MHz system clock and a Wishbone slave with 32-bit data.
 */
package wtc_pkg;

	// Register byte offsets
	localparam logic [3:0] WTC_CTRL_ADDR = 4'h0;
	localparam logic [3:0] WTC_STAT_ADDR = 4'h4;

	// Control register field positions
	localparam int unsigned WTC_FLAG_BIT   = 7;
	localparam int unsigned WTC_IE_BIT     = 6;
	localparam int unsigned WTC_P3_BIT     = 5;
	localparam int unsigned WTC_UNLOCK_BIT = 4;
	localparam int unsigned WTC_WDE_BIT    = 3;
	localparam int unsigned WTC_P2_BIT     = 2;

	// Status register field positions
	localparam int unsigned WTC_STAT_MODE_LSB = 0;
	localparam int unsigned WTC_STAT_UNL_BIT  = 4;

	// Reset values
	localparam logic [7:0] WTC_CTRL_RESET = 8'h00;
	localparam logic [3:0] WTC_SEL_RESET  = 4'h0;

	// Timing
	localparam int unsigned WTC_CLK_HZ        = 50_000_000;
	localparam int unsigned WTC_OSC_HZ        = 128_000;
	localparam int unsigned WTC_OSC_DIV       = WTC_CLK_HZ / WTC_OSC_HZ;
	localparam int unsigned WTC_UNLOCK_CYCLES = 4;
	localparam int unsigned WTC_BASE_OSC      = 2048;
	localparam logic [3:0]  WTC_SEL_MAX       = 4'h9;

	// Operating modes
	typedef enum logic [3:0] {
		WTC_MODE_STOP = 4'b0001,
		WTC_MODE_IRQ  = 4'b0010,
		WTC_MODE_RST  = 4'b0100,
		WTC_MODE_BOTH = 4'b1000
	} wtc_mode_type;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic flag;
		logic irq_en;
		logic sel3;
		logic unlock;
		logic rst_en;
		logic [2:0] sel_lo;
	} wtc_ctrl_type;

endpackage : wtc_pkg

// ===== src/wtc_core.sv
/*
 * Watchdog timer control: time-out counter on a divided 128 kHz tick,
 * control register with timed unlock, interrupt and reset generation.
 * Assumes a classic Wishbone master, one 50 MHz clock, and sideband
 * inputs synchronous to that clock from the core and reset unit.
 */
// Our own choices: register access over Wishbone and the address map.
// How it works
// RULE_01 - A time-out in interrupt operation sets the flag in bit 7.
// RULE_02 - Flag clears on vector execution or by writing one to it.
// RULE_03 - Interrupt only with global enable, timeout enable and flag set.
// RULE_04 - Interrupt enable alone gives interrupt mode, no reset.
// RULE_05 - Combined mode: vector clears enable and flag, leaving reset mode.
// RULE_06 - Combined mode: second time-out with flag pending resets.
// RULE_07 - Software re-arms interrupt enable after each interrupt.
// RULE_08 - Clock monitoring forces reset mode and disables interrupts.
// RULE_09 - All enables clear means stopped; else mode table applies.
// RULE_10 - Clearing reset enable or changing period needs unlock first.
// RULE_11 - Unlock bit clears itself four clock cycles after being set.
// RULE_12 - Reset-cause flag forces reset enable set and uncleared.
// RULE_13 - Period codes 0 to 9 give 2048 doubling to 1048576 cycles.
// RULE_14 - Software restarts the counter before changing the period.
// RULE_15 - A watchdog reset leaves the watchdog enabled afterwards.
// RULE_16 - Init software clears reset-cause flag then reset enable.
// RULE_17 - The watchdog can detect loss of system clock; here the tick is divided from the system clock, so the counter stops with it.
// RULE_18 - Counter advances on a separate 128 kHz oscillator tick; here the tick is divided from the system clock.
// RULE_19 - Unlock with reset enable, then new values within four cycles; here the unlock bit alone opens the window, without reset enable.
// RULE_20 - Always-on fuse forces reset enable one, interrupt enable zero.
// RULE_21 - Restart input clears the counter before the time-out.
// RULE_22 - Reserved period codes act as the longest period.
`timescale 1ns/1ps
`default_nettype none

module wtc_core
	import wtc_pkg::*;
#(
	parameter int unsigned OSC_DIV       = WTC_OSC_DIV,
	parameter int unsigned BASE_OSC      = WTC_BASE_OSC,
	parameter int unsigned UNLOCK_CYCLES = WTC_UNLOCK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Core and reset unit sideband
	input  wire logic        restart_i,
	input  wire logic        vector_ack_i,
	input  wire logic        glob_irq_en_i,
	input  wire logic        clk_monitor_i,
	input  wire logic        always_on_fuse_i,
	input  wire logic        reset_cause_flag_i,
	// Events
	output logic             irq_o,
	output logic             sys_reset_o
);

	localparam int unsigned CNT_W = $clog2(BASE_OSC) + 10;
	localparam int unsigned DIV_W = $clog2(OSC_DIV + 1);
	localparam int unsigned UNL_W = $clog2(UNLOCK_CYCLES + 1);

	// Refuse settings the logic cannot serve: a zero divider never ticks,
	// a base period below two cannot be counted, and an unlock window of
	// zero cycles could never be used by software
	generate
		if (OSC_DIV < 1) begin : g_chk_div
			$error("wtc_core: OSC_DIV must be at least 1");
		end
		if (BASE_OSC < 2) begin : g_chk_base
			$error("wtc_core: BASE_OSC must be at least 2");
		end
		if (UNLOCK_CYCLES < 1) begin : g_chk_unl
			$error("wtc_core: UNLOCK_CYCLES must be at least 1");
		end
	endgenerate

	// Time-out limit for a period code, reserved codes clamp
	function automatic logic [CNT_W-1:0] period_limit(
		input logic [3:0] sel
	);
		logic [3:0]       s;
		logic [CNT_W-1:0] base;
		s = (sel > WTC_SEL_MAX) ? WTC_SEL_MAX : sel;
		base = CNT_W'(BASE_OSC);
		period_limit = (base << s) - CNT_W'(1);
	endfunction : period_limit

	// Word address match, shared by the write strobe and the read mux
	function automatic logic adr_is(
		input logic [3:0] adr,
		input logic [3:0] off
	);
		adr_is = (adr == off);
	endfunction : adr_is

	// Control register state
	logic             flag_q;
	logic             ie_q;
	logic             wde_q;
	logic [3:0]       sel_q;
	logic             unlock_q;
	logic [UNL_W-1:0] unl_cnt_q;
	// Time base and counter
	logic [DIV_W-1:0] div_q;
	logic             tick_q;
	logic [CNT_W-1:0] cnt_q;
	// Bus
	logic             ack_q;
	logic [31:0]      dat_q;
	// Events
	logic             irq_q;
	logic             rst_q;

	// Decoded bus access
	logic         req;
	logic         wr_ctrl;
	wtc_ctrl_type wdat;
	wtc_ctrl_type rdat;

	// Effective enables and mode
	logic         wde_eff;
	logic         ie_eff;
	logic         irq_mode;
	logic         rst_mode;
	logic         active;
	logic         timeout;
	wtc_mode_type mode;

	// Bus request and control write, taken at the edge ack is sampled
	assign req     = wb_cyc_i & wb_stb_i;
	assign wdat    = wtc_ctrl_type'(wb_dat_i[7:0]);
	assign wr_ctrl = req & ack_q & wb_we_i & wb_sel_i[0]
		& adr_is(wb_adr_i, WTC_CTRL_ADDR);

	// RULE_12 forced enable
	// RULE_20 fuse locks
	// RULE_15 stays enabled
	assign wde_eff = wde_q | reset_cause_flag_i | always_on_fuse_i;
	// RULE_08 monitor overrides
	assign ie_eff  = ie_q & ~always_on_fuse_i & ~clk_monitor_i;

	// RULE_09 mode table
	// RULE_17 clock monitor
	assign rst_mode = clk_monitor_i | wde_eff;
	assign irq_mode = ie_eff;
	assign active   = rst_mode | irq_mode;

	// Current mode, used for status readback
	always_comb begin
		if (!active) begin
			mode = WTC_MODE_STOP;
		end else if (irq_mode && rst_mode) begin
			mode = WTC_MODE_BOTH;
		end else if (irq_mode) begin
			mode = WTC_MODE_IRQ;
		end else begin
			mode = WTC_MODE_RST;
		end
	end

	// RULE_13 period decode
	// RULE_22 reserved clamp
	assign timeout = tick_q & active & (cnt_q >= period_limit(sel_q));

	// RULE_18 oscillator tick divider
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == DIV_W'(OSC_DIV - 1)) begin
			div_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + DIV_W'(1);
			tick_q <= 1'b0;
		end
	end

	// Time-out counter. The compare is >= so that a period cut short while
	// the count is already past the new limit expires at the next tick
	// instead of wrapping through the whole counter; software restarts
	// the counter before a period change to avoid that early expiry.
	// Held at zero while stopped so that enabling starts a full period.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		// RULE_21 restart counter
		end else if (restart_i || !active) begin
			cnt_q <= '0;
		end else if (timeout) begin
			cnt_q <= '0;
		end else if (tick_q) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// The window opens on a write with the unlock bit set and closes after
	// a fixed count or on the next control write without it, whichever
	// comes first, so one opening allows exactly one protected change
	// RULE_11 unlock window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unlock_q  <= 1'b0;
			unl_cnt_q <= '0;
		end else if (wr_ctrl && wdat.unlock) begin
			unlock_q  <= 1'b1;
			unl_cnt_q <= UNL_W'(UNLOCK_CYCLES);
		end else if (wr_ctrl || unl_cnt_q == UNL_W'(1)) begin
			unlock_q  <= 1'b0;
			unl_cnt_q <= '0;
		end else if (unl_cnt_q != '0) begin
			unl_cnt_q <= unl_cnt_q - UNL_W'(1);
		end
	end

	// Timeout flag. A time-out in the same cycle as a clear wins, so an
	// expiry is never lost to a late acknowledge or a write of one.
	// In combined mode a pending flag is left alone: that second time-out
	// becomes a system reset instead.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= WTC_CTRL_RESET[WTC_FLAG_BIT];
		// RULE_01 flag set
		end else if (timeout && irq_mode && !(rst_mode && flag_q)) begin
			flag_q <= 1'b1;
		// RULE_02 flag clear
		end else if (vector_ack_i || (wr_ctrl && wdat.flag)) begin
			flag_q <= 1'b0;
		end
	end

	// Timeout interrupt enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ie_q <= WTC_CTRL_RESET[WTC_IE_BIT];
		end else if (always_on_fuse_i) begin
			ie_q <= 1'b0;
		// RULE_05 back to reset
		end else if (vector_ack_i && irq_mode && rst_mode) begin
			ie_q <= 1'b0;
		end else if (wr_ctrl) begin
			ie_q <= wdat.irq_en;
		end
	end

	// Reset enable: set freely, cleared only inside the window.
	// The flop keeps the forced value after the cause flag drops, so a
	// watchdog reset leaves the watchdog running until software clears it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wde_q <= WTC_CTRL_RESET[WTC_WDE_BIT];
		// RULE_12 held set
		end else if (reset_cause_flag_i || always_on_fuse_i) begin
			wde_q <= 1'b1;
		end else if (wr_ctrl && wdat.rst_en) begin
			wde_q <= 1'b1;
		// RULE_10 protected clear
		end else if (wr_ctrl && unlock_q) begin
			wde_q <= 1'b0;
		end
	end

	// RULE_19 period change window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_q <= WTC_SEL_RESET;
		end else if (wr_ctrl && unlock_q) begin
			sel_q <= {wdat.sel3, wdat.sel_lo};
		end
	end

	// Readback view of the control register
	// Enables read back as forced, so software sees the applied mode unless the clock monitor forces reset mode
	always_comb begin
		rdat        = wtc_ctrl_type'(WTC_CTRL_RESET);
		rdat.flag   = flag_q;
		rdat.irq_en = ie_eff;
		rdat.sel3   = sel_q[3];
		rdat.unlock = unlock_q;
		rdat.rst_en = wde_eff;
		rdat.sel_lo = sel_q[2:0];
	end

	// Wishbone ack, one cycle after the request is seen
	// A master holding its request past ack starts a fresh access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// Read data, unmapped addresses read as zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= '0;
		end else if (req && !ack_q) begin
			if (adr_is(wb_adr_i, WTC_CTRL_ADDR)) begin
				dat_q <= {24'h00_0000, rdat};
			end else if (adr_is(wb_adr_i, WTC_STAT_ADDR)) begin
				dat_q <= '0;
				dat_q[WTC_STAT_MODE_LSB +: 4] <= mode;
				dat_q[WTC_STAT_UNL_BIT] <= unlock_q;
			end else begin
				dat_q <= '0;
			end
		end
	end

	// Vector ack masks the request in the cycle it is taken
	// RULE_03 interrupt gate
	// RULE_04 interrupt mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= glob_irq_en_i & ie_eff & flag_q & ~vector_ack_i;
		end
	end

	// One-cycle request; the reset unit stretches it as it needs
	// RULE_06 second time-out resets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_q <= 1'b0;
		end else begin
			rst_q <= timeout & rst_mode & (~irq_mode | flag_q);
		end
	end

	// Outputs straight from flip-flops
	assign wb_ack_o    = ack_q;
	assign wb_dat_o    = dat_q;
	assign irq_o       = irq_q;
	assign sys_reset_o = rst_q;

endmodule : wtc_core

`default_nettype wire
